// file: hdl/mbx_regs.vh
// Constants of the serial register slave
// Operation
// - Bad function, address or data field gets an exception reply.
// - Exception function byte is the received function code plus 80h.
// - Unsupported function code gives exception code 01.
// - Register address outside the map gives exception code 02.
// - Malformed data field of a valid request gives exception code 03.
// - ASCII reply: colon, hex pairs for address, function, code, LRC, then CR LF.
// - RTU frames sit between idle gaps of at least 3.5 characters.
// - Word 0000h is signed discharge temperature in 0.1 degree units.
// - Temperature word reads F334h while its sensor is in alarm.
// - Word 0001h is flow rate; reads 8000h during pressure sensor alarm.
// - Word 0002h is discharge pressure; reads F334h during pressure sensor alarm.
// - Word 0003h is conductivity; zero without option, 8000h during its alarm.
// - Temperature word includes the panel offset when offset is enabled.
// - Words 0004h to 0007h are read-only status and alarm flags.
// - Word 000Bh is the read/write setpoint, two's complement, 0.1 degree steps.
// - Word 000Ch is the read/write operation command word.
// - Words 0009h and 000Ah show data selected by word 000Fh.
// - A read starting at 0100h is beyond the map and gets code 02.
// - Function 06 writes one word and echoes address and value.
// - Function 16 writes consecutive words and echoes start and count.
`ifndef MBX_REGS_VH
`define MBX_REGS_VH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define MBX_REG_TEMP 4'h0
`define MBX_REG_FLOW 4'h1
`define MBX_REG_PRESS 4'h2
`define MBX_REG_COND 4'h3
`define MBX_REG_STATUS 4'h4
`define MBX_REG_ALARM1 4'h5
`define MBX_REG_ALARM2 4'h6
`define MBX_REG_ALARM3 4'h7
`define MBX_REG_DISP1 4'h9
`define MBX_REG_DISP2 4'hA
`define MBX_REG_SETPT 4'hB
`define MBX_REG_CMD 4'hC
`define MBX_REG_SEL 4'hF
`define MBX_REG_COUNT 17'h00010
`define MBX_MAX_QTY 16'h0010
`define MBX_RESET_WORD 16'h0000
// ----------------------------------------
// Sentinels, codes, characters
// ----------------------------------------
`define MBX_SENT_F334 16'hF334
`define MBX_SENT_8000 16'h8000
`define MBX_FC_RD_HOLD 8'h03
`define MBX_FC_RD_IN 8'h04
`define MBX_FC_WR_ONE 8'h06
`define MBX_FC_WR_MULTI 8'h10
`define MBX_EXC_FLAG 8'h80
`define MBX_EXC_NONE 8'h00
`define MBX_EXC_FUNC 8'h01
`define MBX_EXC_ADDR 8'h02
`define MBX_EXC_DATA 8'h03
`define MBX_CH_COLON 8'h3A
`define MBX_CH_CR 8'h0D
`define MBX_CH_LF 8'h0A
`define MBX_CRC_INIT 16'hFFFF
`define MBX_CRC_POLY 16'hA001
`define MBX_BUF_DEPTH 6'd48
`define MBX_FIX_PLEN 6'd6
// ----------------------------------------
// Timing
// ----------------------------------------
`define MBX_CLK_HZ 64'd200000000
`define MBX_BAUD 64'd19200
`define MBX_CHAR_BITS 64'd11
`define MBX_GAP_CHARS_X10 64'd35
`define MBX_GAP_CYCLES ((`MBX_GAP_CHARS_X10 * `MBX_CHAR_BITS * `MBX_CLK_HZ + 64'd10 * `MBX_BAUD - 64'd1) / (64'd10 * `MBX_BAUD))
`endif

// file: hdl/mbx_slave.v
// Serial register slave with exception replies and sixteen-word map
`timescale 1ns/10ps
`include "mbx_regs.vh"
module mbx_slave #(
	parameter GAP_CYCLES = `MBX_GAP_CYCLES
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Link configuration
	input wire ascii_mode,
	input wire [7:0] unit_address,
	// Received characters
	input wire rx_valid,
	input wire [7:0] rx_data,
	// Transmitted characters
	output wire tx_valid,
	output wire [7:0] tx_data,
	input wire tx_ready,
	// Measurements and flags
	input wire [15:0] temp_meas,
	input wire [15:0] temp_offset,
	input wire offset_en,
	input wire temp_sensor_alarm,
	input wire [15:0] flow_meas,
	input wire [15:0] press_meas,
	input wire press_sensor_alarm,
	input wire [15:0] cond_meas,
	input wire cond_option,
	input wire cond_sensor_alarm,
	input wire [15:0] status_flags,
	input wire [15:0] alarm_flags_one,
	input wire [15:0] alarm_flags_two,
	input wire [15:0] alarm_flags_three,
	input wire [15:0] display_value_one,
	input wire [15:0] display_value_two,
	// Written words
	output wire [15:0] temperature_setpoint,
	output wire [15:0] operation_command,
	output wire operation_command_strobe,
	output wire [15:0] display_select
);
localparam [5:0] ST_RX = 6'h01;
localparam [5:0] ST_EXEC = 6'h02;
localparam [5:0] ST_WR = 6'h04;
localparam [5:0] ST_HEAD = 6'h08;
localparam [5:0] ST_BODY = 6'h10;
localparam [5:0] ST_TAIL = 6'h20;
localparam [19:0] GAP_W = GAP_CYCLES[19:0];

reg [5:0] state_reg;
reg [5:0] nb_reg;
reg act_reg;
reg bad_reg;
reg nib_reg;
reg [3:0] hi_reg;
reg [7:0] lrc_reg;
reg [15:0] crc_reg;
reg [19:0] gap_reg;
reg [7:0] exc_reg;
reg [5:0] len_reg;
reg [5:0] idx_reg;
reg [3:0] wi_reg;
reg txv_reg;
reg [7:0] txd_reg;
reg [15:0] setpoint_reg;
reg [15:0] command_reg;
reg [15:0] select_reg;
reg strobe_reg;
reg [7:0] buf_mem [0:47];

// ----------------------------------------
// Checksum and hex character helpers
// ----------------------------------------
function [15:0] crc_upd;
	input [15:0] c;
	input [7:0] b;
	integer k;
	reg [15:0] t;
	begin
		t = c ^ {8'h00, b};
		for (k = 0; k < 8; k = k + 1) begin
			t = t[0] ? ((t >> 1) ^ `MBX_CRC_POLY) : (t >> 1);
		end
		crc_upd = t;
	end
endfunction

function [7:0] hex_char;
	input [3:0] n;
	begin
		hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	end
endfunction

// ----------------------------------------
// Receive decode
// ----------------------------------------
wire is_dig = (rx_data >= 8'h30) && (rx_data <= 8'h39);
wire is_up = (rx_data >= 8'h41) && (rx_data <= 8'h46);
wire is_lo = (rx_data >= 8'h61) && (rx_data <= 8'h66);
wire is_hex = is_dig || is_up || is_lo;
wire [3:0] rx_nib = is_dig ? rx_data[3:0] : (rx_data[3:0] + 4'h9);
wire in_rx = (state_reg == ST_RX);
wire fits = nb_reg < `MBX_BUF_DEPTH;
wire a_store = act_reg && is_hex && nib_reg && (rx_data != `MBX_CH_COLON);
wire store = in_rx && rx_valid && fits && (ascii_mode ? a_store : 1'b1);
wire [7:0] st_byte = ascii_mode ? {hi_reg, rx_nib} : rx_data;

always @(posedge clk) begin
	if (store) begin
		buf_mem[nb_reg] <= st_byte;
	end
end

// ----------------------------------------
// Request check
// ----------------------------------------
wire [7:0] fc = buf_mem[1];
wire [15:0] start = {buf_mem[2], buf_mem[3]};
wire [15:0] qty = {buf_mem[4], buf_mem[5]};
wire [7:0] bcnt = buf_mem[6];
wire [5:0] plen = nb_reg - (ascii_mode ? 6'd1 : 6'd2);
wire [16:0] span = {1'b0, start} + {1'b0, qty};
wire qty_ok = (qty != 16'h0000) && (qty <= `MBX_MAX_QTY);
wire chk_ok = ascii_mode ? (lrc_reg == 8'h00) : (crc_reg == 16'h0000);
wire min_ok = nb_reg >= (ascii_mode ? 6'd3 : 6'd4);
wire frame_ok = !bad_reg && min_ok && chk_ok && (buf_mem[0] == unit_address);
wire is_read = (fc == `MBX_FC_RD_HOLD) || (fc == `MBX_FC_RD_IN);
reg [7:0] exc_c;
reg [5:0] len_c;

always @* begin
	exc_c = `MBX_EXC_NONE;
	len_c = `MBX_FIX_PLEN;
	case (fc)
		`MBX_FC_RD_HOLD, `MBX_FC_RD_IN: begin
			if ((plen != `MBX_FIX_PLEN) || !qty_ok) begin
				exc_c = `MBX_EXC_DATA;
			end else if (span > `MBX_REG_COUNT) begin
				exc_c = `MBX_EXC_ADDR;
			end else begin
				len_c = 6'd3 + {qty[4:0], 1'b0};
			end
		end
		`MBX_FC_WR_ONE: begin
			if (plen != `MBX_FIX_PLEN) begin
				exc_c = `MBX_EXC_DATA;
			end else if (start > 16'h000F) begin
				exc_c = `MBX_EXC_ADDR;
			end
		end
		`MBX_FC_WR_MULTI: begin
			if (({3'b000, plen} != ({1'b0, bcnt} + 9'd7)) || !qty_ok || (bcnt != {qty[6:0], 1'b0})) begin
				exc_c = `MBX_EXC_DATA;
			end else if (span > `MBX_REG_COUNT) begin
				exc_c = `MBX_EXC_ADDR;
			end
		end
		default: begin
			exc_c = `MBX_EXC_FUNC;
		end
	endcase
	if (exc_c != `MBX_EXC_NONE) begin
		len_c = 6'd3;
	end
end

// ----------------------------------------
// Register map read
// ----------------------------------------
wire [5:0] doff = idx_reg - 6'd3;
wire [3:0] rd_idx = start[3:0] + doff[4:1];
reg [15:0] rd_word;

always @* begin
	case (rd_idx)
		`MBX_REG_TEMP: rd_word = temp_sensor_alarm ? `MBX_SENT_F334 :
			(offset_en ? (temp_meas + temp_offset) : temp_meas);
		`MBX_REG_FLOW: rd_word = press_sensor_alarm ? `MBX_SENT_8000 : flow_meas;
		`MBX_REG_PRESS: rd_word = press_sensor_alarm ? `MBX_SENT_F334 : press_meas;
		`MBX_REG_COND: rd_word = !cond_option ? `MBX_RESET_WORD :
			(cond_sensor_alarm ? `MBX_SENT_8000 : cond_meas);
		`MBX_REG_STATUS: rd_word = status_flags;
		`MBX_REG_ALARM1: rd_word = alarm_flags_one;
		`MBX_REG_ALARM2: rd_word = alarm_flags_two;
		`MBX_REG_ALARM3: rd_word = alarm_flags_three;
		`MBX_REG_DISP1: rd_word = display_value_one;
		`MBX_REG_DISP2: rd_word = display_value_two;
		`MBX_REG_SETPT: rd_word = setpoint_reg;
		`MBX_REG_CMD: rd_word = command_reg;
		`MBX_REG_SEL: rd_word = select_reg;
		default: rd_word = `MBX_RESET_WORD;
	endcase
end

// ----------------------------------------
// Reply byte and character
// ----------------------------------------
reg [7:0] rsp_b;
always @* begin
	if (idx_reg == 6'd0) begin
		rsp_b = buf_mem[0];
	end else if (idx_reg == 6'd1) begin
		rsp_b = (exc_reg != `MBX_EXC_NONE) ? (fc | `MBX_EXC_FLAG) : fc;
	end else if (exc_reg != `MBX_EXC_NONE) begin
		rsp_b = exc_reg;
	end else if (is_read) begin
		if (idx_reg == 6'd2) begin
			rsp_b = {qty[6:0], 1'b0};
		end else begin
			rsp_b = doff[0] ? rd_word[7:0] : rd_word[15:8];
		end
	end else begin
		rsp_b = buf_mem[idx_reg];
	end
end

wire in_data = idx_reg < len_reg;
wire [7:0] chk_b = ascii_mode ? (8'h00 - lrc_reg) : ((idx_reg == len_reg) ? crc_reg[7:0] : crc_reg[15:8]);
wire [7:0] lb = in_data ? rsp_b : chk_b;
wire [5:0] last_idx = len_reg + (ascii_mode ? 6'd0 : 6'd1);
reg have;
reg [7:0] ch;

always @* begin
	have = 1'b0;
	ch = 8'h00;
	case (state_reg)
		ST_HEAD: begin
			have = ascii_mode;
			ch = `MBX_CH_COLON;
		end
		ST_BODY: begin
			have = 1'b1;
			ch = !ascii_mode ? lb : hex_char(nib_reg ? lb[3:0] : lb[7:4]);
		end
		ST_TAIL: begin
			have = 1'b1;
			ch = nib_reg ? `MBX_CH_LF : `MBX_CH_CR;
		end
		default: begin
			have = 1'b0;
		end
	endcase
end
wire load = have && (!txv_reg || tx_ready);

// ----------------------------------------
// Word writes
// ----------------------------------------
wire [5:0] wp = 6'd7 + {1'b0, wi_reg, 1'b0};
reg wr_go;
reg [3:0] wr_idx;
reg [15:0] wr_val;

always @* begin
	wr_go = 1'b0;
	wr_idx = start[3:0];
	wr_val = qty;
	if ((state_reg == ST_EXEC) && frame_ok && (exc_c == `MBX_EXC_NONE) && (fc == `MBX_FC_WR_ONE)) begin
		wr_go = 1'b1;
	end else if (state_reg == ST_WR) begin
		wr_go = 1'b1;
		wr_idx = start[3:0] + wi_reg;
		wr_val = {buf_mem[wp], buf_mem[wp + 6'd1]};
	end
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		setpoint_reg <= `MBX_RESET_WORD;
		command_reg <= `MBX_RESET_WORD;
		select_reg <= `MBX_RESET_WORD;
		strobe_reg <= 1'b0;
	end else begin
		strobe_reg <= wr_go && (wr_idx == `MBX_REG_CMD);
		if (wr_go) begin
			case (wr_idx)
				`MBX_REG_SETPT: setpoint_reg <= wr_val;
				`MBX_REG_CMD: command_reg <= wr_val;
				`MBX_REG_SEL: select_reg <= wr_val;
				default: ;
			endcase
		end
	end
end

// ----------------------------------------
// Frame sequencer
// ----------------------------------------
task go_idle;
	begin
		state_reg <= ST_RX;
		nb_reg <= 6'd0;
		act_reg <= 1'b0;
		bad_reg <= 1'b0;
		nib_reg <= 1'b0;
		gap_reg <= 20'd0;
		lrc_reg <= 8'h00;
		crc_reg <= `MBX_CRC_INIT;
	end
endtask

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		state_reg <= ST_RX;
		nb_reg <= 6'd0;
		act_reg <= 1'b0;
		bad_reg <= 1'b0;
		nib_reg <= 1'b0;
		hi_reg <= 4'h0;
		gap_reg <= 20'd0;
		lrc_reg <= 8'h00;
		crc_reg <= `MBX_CRC_INIT;
		exc_reg <= `MBX_EXC_NONE;
		len_reg <= 6'd0;
		idx_reg <= 6'd0;
		wi_reg <= 4'h0;
		txv_reg <= 1'b0;
		txd_reg <= 8'h00;
	end else begin
		if (load) begin
			txv_reg <= 1'b1;
			txd_reg <= ch;
		end else if (tx_ready) begin
			txv_reg <= 1'b0;
		end
		case (state_reg)
			ST_RX: begin
				if (rx_valid) begin
					gap_reg <= 20'd0;
				end else if (gap_reg != GAP_W) begin
					gap_reg <= gap_reg + 20'd1;
				end
				if (ascii_mode) begin
					if (rx_valid && (rx_data == `MBX_CH_COLON)) begin
						act_reg <= 1'b1;
						nb_reg <= 6'd0;
						nib_reg <= 1'b0;
						bad_reg <= 1'b0;
						lrc_reg <= 8'h00;
					end else if (rx_valid && act_reg) begin
						if (rx_data == `MBX_CH_LF) begin
							act_reg <= 1'b0;
							bad_reg <= bad_reg | nib_reg;
							state_reg <= ST_EXEC;
						end else if (rx_data == `MBX_CH_CR) begin
							bad_reg <= bad_reg;
						end else if (!is_hex) begin
							bad_reg <= 1'b1;
						end else if (!nib_reg) begin
							hi_reg <= rx_nib;
							nib_reg <= 1'b1;
						end else begin
							nib_reg <= 1'b0;
							if (fits) begin
								nb_reg <= nb_reg + 6'd1;
								lrc_reg <= lrc_reg + st_byte;
							end else begin
								bad_reg <= 1'b1;
							end
						end
					end
				end else if (rx_valid) begin
					if (fits) begin
						nb_reg <= nb_reg + 6'd1;
						crc_reg <= crc_upd(crc_reg, rx_data);
					end else begin
						bad_reg <= 1'b1;
					end
				end else if ((nb_reg != 6'd0) && (gap_reg == GAP_W)) begin
					state_reg <= ST_EXEC;
				end
			end
			ST_EXEC: begin
				exc_reg <= exc_c;
				len_reg <= len_c;
				idx_reg <= 6'd0;
				wi_reg <= 4'h0;
				nib_reg <= 1'b0;
				lrc_reg <= 8'h00;
				crc_reg <= `MBX_CRC_INIT;
				if (!frame_ok) begin
					go_idle;
				end else if ((exc_c == `MBX_EXC_NONE) && (fc == `MBX_FC_WR_MULTI)) begin
					state_reg <= ST_WR;
				end else begin
					state_reg <= ST_HEAD;
				end
			end
			ST_WR: begin
				wi_reg <= wi_reg + 4'h1;
				if (wi_reg == (qty[3:0] - 4'h1)) begin
					state_reg <= ST_HEAD;
				end
			end
			ST_HEAD: begin
				if (!ascii_mode || load) begin
					state_reg <= ST_BODY;
				end
			end
			ST_BODY: begin
				if (load) begin
					if (ascii_mode && !nib_reg) begin
						nib_reg <= 1'b1;
					end else begin
						nib_reg <= 1'b0;
						if (in_data) begin
							lrc_reg <= lrc_reg + lb;
							crc_reg <= crc_upd(crc_reg, lb);
						end
						idx_reg <= idx_reg + 6'd1;
						if (idx_reg == last_idx) begin
							if (ascii_mode) begin
								state_reg <= ST_TAIL;
							end else begin
								go_idle;
							end
						end
					end
				end
			end
			ST_TAIL: begin
				if (load) begin
					if (nib_reg) begin
						go_idle;
					end else begin
						nib_reg <= 1'b1;
					end
				end
			end
			default: begin
				go_idle;
			end
		endcase
	end
end

// ----------------------------------------
// Outputs
// ----------------------------------------
assign tx_valid = txv_reg;
assign tx_data = txd_reg;
assign temperature_setpoint = setpoint_reg;
assign operation_command = command_reg;
assign operation_command_strobe = strobe_reg;
assign display_select = select_reg;
endmodule // mbx_slave

// file: verif/mbx_master_model.sv
// Master controller model: sends request characters, takes replies
`timescale 1ns/10ps
module mbx_master_model (
	// Clock
	input wire clk,
	// Request side
	output logic rx_valid,
	output logic [7:0] rx_data,
	// Reply side
	input wire tx_valid,
	input wire [7:0] tx_data,
	output logic tx_ready
);
	logic slow = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// One character per two cycles, inverse value on the idle line
	task automatic put(input logic [7:0] b);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
		@(posedge clk);
	endtask
	// Slow mode accepts every other cycle
	always @(posedge clk)
		tx_ready <= slow ? ~tx_ready : 1'b1;
endmodule // mbx_master_model

// file: verif/mbx_slave_properties.sv
// Port checks for the serial register slave
`timescale 1ns/10ps
module mbx_slave_checker #(
	parameter GAP_CYCLES = 20
) (
	// Clock, reset, mode
	input wire clk,
	input wire rst_n,
	input wire ascii_mode,
	// Link
	input wire rx_valid,
	input wire tx_valid,
	input wire [7:0] tx_data,
	input wire tx_ready,
	// Written words
	input wire [15:0] temperature_setpoint,
	input wire [15:0] operation_command,
	input wire operation_command_strobe,
	input wire [15:0] display_select
);
	// --------------------
	// Helpers and checks
	// --------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [19:0] quiet;
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
			quiet <= 20'h00000;
		else if (rx_valid)
			quiet <= 20'h00000;
		else if (quiet != 20'hFFFFF)
			quiet <= quiet + 20'h00001;
	sequence s_taken(c); ascii_mode && tx_valid && tx_ready && tx_data == c; endsequence
	property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("reply character changed before taken");
	property p_ascii_start; ascii_mode && $rose(tx_valid) |-> tx_data == 8'h3A; endproperty
	a_ascii_start: assert property (p_ascii_start) else $error("ascii reply not opened by colon");
	property p_ascii_chars; ascii_mode && tx_valid |-> tx_data inside {8'h3A, 8'h0D, 8'h0A,
		[8'h30:8'h39], [8'h41:8'h46]}; endproperty
	a_ascii_chars: assert property (p_ascii_chars) else $error("ascii reply holds non-hex character");
	property p_ascii_end; s_taken(8'h0D) |=> tx_valid && tx_data == 8'h0A; endproperty
	a_ascii_end: assert property (p_ascii_end) else $error("carriage return not followed by line feed");
	property p_lf_last; s_taken(8'h0A) |=> !tx_valid; endproperty
	a_lf_last: assert property (p_lf_last) else $error("reply continues after line feed");
	property p_rtu_gap; !ascii_mode && $rose(tx_valid) |-> quiet >= GAP_CYCLES; endproperty
	a_rtu_gap: assert property (p_rtu_gap) else $error("rtu reply began inside idle gap");
	property p_strb_pulse; operation_command_strobe |=> !operation_command_strobe; endproperty
	a_strb_pulse: assert property (p_strb_pulse) else $error("command strobe longer than one cycle");
	property p_cfg_quiet; tx_valid ##1 tx_valid |-> $stable(temperature_setpoint) && $stable(display_select);
	endproperty
	a_cfg_quiet: assert property (p_cfg_quiet) else $error("written word changed during reply");
	property p_rst_idle; $rose(rst_n) |-> !tx_valid && !operation_command_strobe &&
		temperature_setpoint == 16'h0000 && operation_command == 16'h0000 && display_select == 16'h0000; endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
endmodule // mbx_slave_checker
bind mbx_slave mbx_slave_checker #(.GAP_CYCLES(GAP_CYCLES)) u_mbx_slave_checker (.clk(clk), .rst_n(rst_n),
	.ascii_mode(ascii_mode), .rx_valid(rx_valid), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
	.temperature_setpoint(temperature_setpoint), .operation_command(operation_command),
	.operation_command_strobe(operation_command_strobe), .display_select(display_select));

// file: verif/modbus_exception_and_register_map_tb_top.sv
// Self-checking bench for the serial register slave
`timescale 1ns/10ps
module modbus_exception_and_register_map_tb_top;
	localparam int GAP = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ascii_mode = 1'b1;
	logic [7:0] unit_address = 8'h01;
	logic rx_valid, tx_valid, tx_ready, operation_command_strobe;
	logic [7:0] rx_data, tx_data;
	logic [15:0] temp_meas = 16'h00EB, temp_offset = 16'h000A, flow_meas = 16'h06F3, press_meas = 16'h008C;
	logic [15:0] cond_meas = 16'h01F4, status_flags = 16'h1234, alarm_flags_one = 16'h0021;
	logic [15:0] alarm_flags_two = 16'h0300, alarm_flags_three = 16'h4001;
	logic [15:0] display_value_one = 16'h0ABC, display_value_two = 16'h0DEF;
	logic offset_en = 1'b1, temp_sensor_alarm = 1'b0, press_sensor_alarm = 1'b0;
	logic cond_option = 1'b1, cond_sensor_alarm = 1'b0;
	logic [15:0] temperature_setpoint, operation_command, display_select;
	logic [7:0] rq[$], rs[$], w[$], got[$];
	int n_mismatch = 0, tests_run = 0, n_strb = 0;
	always #2.5 clk = ~clk;
	mbx_slave #(.GAP_CYCLES(GAP)) u_mbx_slave (.clk(clk), .rst_n(rst_n), .ascii_mode(ascii_mode),
		.unit_address(unit_address), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .temp_meas(temp_meas), .temp_offset(temp_offset), .offset_en(offset_en),
		.temp_sensor_alarm(temp_sensor_alarm), .flow_meas(flow_meas), .press_meas(press_meas),
		.press_sensor_alarm(press_sensor_alarm), .cond_meas(cond_meas), .cond_option(cond_option),
		.cond_sensor_alarm(cond_sensor_alarm), .status_flags(status_flags), .alarm_flags_one(alarm_flags_one),
		.alarm_flags_two(alarm_flags_two), .alarm_flags_three(alarm_flags_three),
		.display_value_one(display_value_one), .display_value_two(display_value_two),
		.temperature_setpoint(temperature_setpoint), .operation_command(operation_command),
		.operation_command_strobe(operation_command_strobe), .display_select(display_select));
	mbx_master_model u_mbx_master_model (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
	always @(posedge clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			got.push_back(tx_data);
		if (operation_command_strobe === 1'b1)
			n_strb++;
	end
	// --------------------
	// Helpers
	// --------------------
	task automatic print_verdict;
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
	endfunction
	// Frame encoder: LRC in ascii, CRC low byte first in rtu
	task automatic enc(input logic [7:0] q[$], input logic asc);
		logic [15:0] c;
		logic [7:0] s;
		c = 16'hFFFF;
		s = 8'h00;
		foreach (q[i]) begin
			s = s + q[i];
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		s = 8'h00 - s;
		w = {};
		if (asc) begin
			w.push_back(8'h3A);
			foreach (q[i]) begin
				w.push_back(hx(q[i][7:4]));
				w.push_back(hx(q[i][3:0]));
			end
			w.push_back(hx(s[7:4]));
			w.push_back(hx(s[3:0]));
			w.push_back(8'h0D);
			w.push_back(8'h0A);
		end else begin
			w = q;
			w.push_back(c[7:0]);
			w.push_back(c[15:8]);
		end
	endtask
	task automatic xact(input logic asc);
		int t;
		ascii_mode <= asc;
		@(posedge clk);
		enc(rq, asc);
		got = {};
		foreach (w[i])
			u_mbx_master_model.put(w[i]);
		enc(rs, asc);
		t = 0;
		while (got.size() < w.size() && t < 400 + 2 * GAP) begin
			@(posedge clk);
			t++;
		end
		repeat (GAP + 4) @(posedge clk);
		cmp16("reply length", 16'(w.size()), 16'(got.size()));
		foreach (w[i])
			if (i < got.size())
				cmp8("reply byte", w[i], got[i]);
	endtask
	task automatic ww(input logic [15:0] v);
		rs.push_back(v[15:8]);
		rs.push_back(v[7:0]);
	endtask
	// --------------------
	// Scenarios
	// --------------------
	task automatic t_exc;
		logic [7:0] bad[3];
		bad = '{8'h01, 8'h05, 8'h2B};
		rq = '{8'h01, 8'h04, 8'h01, 8'h00, 8'h00, 8'h07};
		rs = '{8'h01, 8'h84, 8'h02};
		xact(1'b1);
		u_mbx_master_model.slow <= 1'b1;
		xact(1'b0);
		u_mbx_master_model.slow <= 1'b0;
		foreach (bad[i]) begin
			rq = '{8'h01, bad[i], 8'h00, 8'h00, 8'h00, 8'h01};
			rs = '{8'h01, bad[i] | 8'h80, 8'h01};
			xact(1'b0);
		end
		rq = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
		rs = '{8'h01, 8'h83, 8'h03};
		xact(1'b1);
		rq = '{8'h01, 8'h03, 8'h00, 8'h0F, 8'h00, 8'h02};
		rs = '{8'h01, 8'h83, 8'h02};
		xact(1'b0);
		rq = '{8'h01, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01};
		rs = '{8'h01, 8'h86, 8'h02};
		xact(1'b0);
		rq = '{8'h01, 8'h10, 8'h00, 8'h0B, 8'h00, 8'h01, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02};
		rs = '{8'h01, 8'h90, 8'h03};
		xact(1'b1);
	endtask
	task automatic t_write;
		int s0;
		logic [7:0] ign[4];
		ign = '{8'h00, 8'h04, 8'h08, 8'h0D};
		rq = '{8'h01, 8'h06, 8'h00, 8'h0B, 8'hFF, 8'h38};
		rs = rq;
		xact(1'b1);
		cmp16("setpoint", 16'hFF38, temperature_setpoint);
		s0 = n_strb;
		rq = '{8'h01, 8'h10, 8'h00, 8'h0B, 8'h00, 8'h02, 8'h04, 8'h00, 8'hEB, 8'h00, 8'h01};
		rs = '{8'h01, 8'h10, 8'h00, 8'h0B, 8'h00, 8'h02};
		xact(1'b0);
		cmp16("setpoint", 16'h00EB, temperature_setpoint);
		cmp16("command", 16'h0001, operation_command);
		cmp16("strobes", 16'h0001, 16'(n_strb - s0));
		rq = '{8'h01, 8'h06, 8'h00, 8'h0F, 8'h00, 8'h03};
		rs = rq;
		xact(1'b0);
		cmp16("select", 16'h0003, display_select);
		foreach (ign[i]) begin
			rq = '{8'h01, 8'h06, 8'h00, ign[i], 8'h55, 8'h55};
			rs = rq;
			xact(1'b0);
		end
	endtask
	task automatic t_meas;
		logic [15:0] v[16];
		v = '{16'h00F5, 16'h06F3, 16'h008C, 16'h01F4, 16'h1234, 16'h0021, 16'h0300, 16'h4001,
			16'h0000, 16'h0ABC, 16'h0DEF, 16'h00EB, 16'h0001, 16'h0000, 16'h0000, 16'h0003};
		rq = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h10};
		rs = '{8'h01, 8'h03, 8'h20};
		foreach (v[i])
			ww(v[i]);
		xact(1'b1);
		temp_sensor_alarm <= 1'b1;
		press_sensor_alarm <= 1'b1;
		cond_sensor_alarm <= 1'b1;
		rq = '{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h04};
		rs = '{8'h01, 8'h04, 8'h08, 8'hF3, 8'h34, 8'h80, 8'h00, 8'hF3, 8'h34, 8'h80, 8'h00};
		xact(1'b0);
		cond_sensor_alarm <= 1'b0;
		cond_option <= 1'b0;
		temp_sensor_alarm <= 1'b0;
		offset_en <= 1'b0;
		rq = '{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h04};
		rs = '{8'h01, 8'h04, 8'h08, 8'h00, 8'hEB, 8'h80, 8'h00, 8'hF3, 8'h34, 8'h00, 8'h00};
		xact(1'b0);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		cmp16("setpoint", 16'h0000, temperature_setpoint);
		cmp16("command", 16'h0000, operation_command);
		cmp16("select", 16'h0000, display_select);
		t_exc;
		t_write;
		t_meas;
		print_verdict;
	end
	initial begin
		// More than ten times the expected run length
		#100000;
		n_mismatch++;
		print_verdict;
	end
endmodule // modbus_exception_and_register_map_tb_top
